// File: design/bopc_pkg.sv
package bopc_pkg;
   // timebase
   localparam int unsigned CLK_HZ      = 50_000_000;
   localparam int unsigned CLK_NS      = 1_000_000_000 / CLK_HZ;
   // fixed off-time, blanking and fast share of the off-time
   localparam int unsigned T_OFF_NS    = 30_000;
   localparam int unsigned T_BLANK_NS  = 1_000;
   localparam int unsigned FAST_NUM    = 5;
   localparam int unsigned FAST_DEN    = 16;
   localparam int unsigned OFF_CYC     = T_OFF_NS / CLK_NS;
   localparam int unsigned BLANK_CYC   = (T_BLANK_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned FAST_CYC    = (OFF_CYC * FAST_NUM) / FAST_DEN;
   localparam int unsigned CNT_W       = 11;
   // register byte offsets
   localparam logic [7:0]  OFS_CTRL    = 8'h00;
   localparam logic [7:0]  OFS_STEP    = 8'h04;
   localparam logic [7:0]  OFS_STATUS  = 8'h08;
   localparam logic [7:0]  OFS_POS     = 8'h0C;
   // control register fields
   localparam int unsigned CTRL_W      = 7;
   localparam int unsigned CTRL_DIS    = 0;
   localparam int unsigned CTRL_WAKE   = 1;
   localparam int unsigned CTRL_RUNN   = 2;
   localparam int unsigned CTRL_MS     = 3;
   localparam int unsigned CTRL_DIR    = 5;
   localparam int unsigned CTRL_OTS    = 6;
   localparam logic [6:0]  CTRL_RESET  = 7'h44;
   // status register fields
   localparam int unsigned ST_RUN      = 0;
   localparam int unsigned ST_LATCH1   = 1;
   localparam int unsigned ST_LATCH2   = 2;
   localparam int unsigned ST_FAULT    = 3;
   localparam int unsigned ST_CHOP1    = 7;
   localparam int unsigned ST_CHOP2    = 12;
   // translator
   localparam int unsigned POS_W       = 5;
   localparam logic [4:0]  HOME_IDX    = 5'h04;

   typedef struct packed {
      logic src_a;
      logic snk_a;
      logic src_b;
      logic snk_b;
   } bopc_gate_t;

   typedef struct packed {
      logic over_temp;
      logic charge_pump_rail_uv;
      logic gate_drive_regulator_fault;
      logic undervoltage_lockout;
   } bopc_fault_t;

   typedef struct packed {
      logic trip;
      logic gnd_short;
      logic zero_cur;
   } bopc_sense_t;

   typedef enum logic [4:0] {
      CH_IDLE  = 5'h01,
      CH_BLANK = 5'h02,
      CH_DRIVE = 5'h04,
      CH_FAST  = 5'h08,
      CH_SLOW  = 5'h10
   } bopc_chop_t;
endpackage : bopc_pkg

// File: design/bopc_sync.sv
`timescale 1ns/1ns
module bopc_sync #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // asynchronous in, synchronous out
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   // two-stage synchroniser, first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule : bopc_sync

// File: design/bopc_chopper.sv
`timescale 1ns/1ns
module bopc_chopper (
   // clock and reset
   input  wire logic               clk,
   input  wire logic               rst_n,
   // control from the top
   input  wire logic               run,
   input  wire logic               positive,
   input  wire logic               mixed,
   input  wire logic               clear_latch,
   input  wire bopc_pkg::bopc_sense_t sense,
   // gate drive and state
   output bopc_pkg::bopc_gate_t    gate,
   output logic                    latched,
   output bopc_pkg::bopc_chop_t    state
);
   logic [bopc_pkg::CNT_W-1:0] cnt;
   logic                       active;

   assign active = run && !latched;

   // gate pattern for a chopper phase and current polarity
   function automatic bopc_pkg::bopc_gate_t gate_of(
      input bopc_pkg::bopc_chop_t s, input logic pos, input logic zero);
      bopc_pkg::bopc_gate_t g;
      g = '0;
      case (s)
         bopc_pkg::CH_BLANK, bopc_pkg::CH_DRIVE: begin
            g = pos ? 4'b1001 : 4'b0110;
         end
         // reverse diagonal on, recirculation through the channels
         bopc_pkg::CH_FAST: begin
            g = zero ? 4'b0000 : (pos ? 4'b0110 : 4'b1001);
         end
         // both low sides on; off near zero so the current cannot reverse
         bopc_pkg::CH_SLOW: begin
            g = zero ? 4'b0000 : 4'b0101;
         end
         default: begin
            g = '0;
         end
      endcase
      return g;
   endfunction : gate_of

   // short-to-ground latch: a new short wins over the clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         latched <= 1'b0;
      end else if (sense.gnd_short && state != bopc_pkg::CH_IDLE) begin
         latched <= 1'b1;
      end else if (clear_latch) begin
         latched <= 1'b0;
      end
   end

   // fixed off-time chopper; a load short simply keeps re-tripping
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= bopc_pkg::CH_IDLE;
         cnt   <= '0;
      end else if (!active) begin
         state <= bopc_pkg::CH_IDLE;
         cnt   <= '0;
      end else begin
         case (state)
            bopc_pkg::CH_IDLE: begin
               state <= bopc_pkg::CH_BLANK;
               cnt   <= '0;
            end
            // trip is ignored while blanking
            bopc_pkg::CH_BLANK: begin
               if (cnt == bopc_pkg::CNT_W'(bopc_pkg::BLANK_CYC - 1)) begin
                  state <= bopc_pkg::CH_DRIVE;
                  cnt   <= '0;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            bopc_pkg::CH_DRIVE: begin
               if (sense.trip) begin
                  state <= mixed ? bopc_pkg::CH_FAST : bopc_pkg::CH_SLOW;
                  cnt   <= '0;
               end
            end
            bopc_pkg::CH_FAST: begin
               if (cnt == bopc_pkg::CNT_W'(bopc_pkg::FAST_CYC - 1)) begin
                  state <= bopc_pkg::CH_SLOW;
               end
               cnt <= cnt + 1'b1;
            end
            bopc_pkg::CH_SLOW: begin
               if (cnt == bopc_pkg::CNT_W'(bopc_pkg::OFF_CYC - 1)) begin
                  state <= bopc_pkg::CH_BLANK;
                  cnt   <= '0;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            default: begin
               state <= bopc_pkg::CH_IDLE;
               cnt   <= '0;
            end
         endcase
      end
   end

   // registered gate drive
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gate <= '0;
      end else begin
         gate <= gate_of(state, positive, sense.zero_cur);
      end
   end

   sequence s_trip_in_blank;
      active && state == bopc_pkg::CH_BLANK && sense.trip;
   endsequence

   a_blank_ignores_trip: assert property (@(posedge clk) disable iff (!rst_n)
      s_trip_in_blank |=> state != bopc_pkg::CH_FAST
                          && state != bopc_pkg::CH_SLOW)
      else $error("trip acted on during blanking");

   a_fast_to_slow: assert property (@(posedge clk) disable iff (!rst_n)
      active && state == bopc_pkg::CH_FAST
      && cnt == bopc_pkg::CNT_W'(bopc_pkg::FAST_CYC - 1)
      |=> state == bopc_pkg::CH_SLOW || !$past(active, 1) || !active)
      else $error("fast decay did not end at its share of off-time");

   a_short_latches_off: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(latched) |-> ##2 gate == '0)
      else $error("latched short left the bridge driven");

   a_off_time_end: assert property (@(posedge clk) disable iff (!rst_n)
      active && state == bopc_pkg::CH_SLOW
      && cnt == bopc_pkg::CNT_W'(bopc_pkg::OFF_CYC - 1) && $stable(active)
      |=> state == bopc_pkg::CH_BLANK || !active)
      else $error("driver did not re-enable after the off-time");
endmodule : bopc_chopper

// File: design/bopc_top.sv
`timescale 1ns/1ns
module bopc_top (
   // clock and reset
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   // ahb-lite slave
   input  wire logic                  hsel,
   input  wire logic [7:0]            haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic                       hreadyout,
   output logic                       hresp,
   output logic [31:0]                hrdata,
   // asynchronous analog indications
   input  wire bopc_pkg::bopc_fault_t fault_pins,
   input  wire bopc_pkg::bopc_sense_t sense1_pins,
   input  wire bopc_pkg::bopc_sense_t sense2_pins,
   // bridge gate drive
   output bopc_pkg::bopc_gate_t       bridge1_gate,
   output bopc_pkg::bopc_gate_t       bridge2_gate,
   // translator and supplies
   output logic [4:0]                 step_index,
   output logic                       phase1_positive,
   output logic                       phase2_positive,
   output logic                       pump_enable,
   output logic                       regulator_enable
);
   logic [bopc_pkg::CTRL_W-1:0] ctrl;
   logic                        step_req;
   logic                        wr_pend;
   logic [7:0]                  wr_addr;
   logic                        wake_q;
   logic                        wake_rise;
   logic                        bus_take;
   logic [31:0]                 rd_val;
   logic [9:0]                  async_in;
   logic [9:0]                  sync_out;
   bopc_pkg::bopc_fault_t       fault;
   bopc_pkg::bopc_sense_t       sense1;
   bopc_pkg::bopc_sense_t       sense2;
   logic                        fault_any;
   logic                        run;
   logic                        out_dis;
   logic                        wake;
   logic                        seq_run;
   logic [1:0]                  ms_sel;
   logic                        dir;
   logic                        ots_supply;
   logic [4:0]                  next_pos;
   logic [4:0]                  step_inc;
   logic                        mixed1;
   logic                        mixed2;
   logic                        latched1;
   logic                        latched2;
   bopc_pkg::bopc_chop_t        chop1;
   bopc_pkg::bopc_chop_t        chop2;

   // magnitude of a phase current shrinking in the stepping direction
   function automatic logic mag_falling(input logic [4:0] p,
                                        input logic d,
                                        input logic second);
      logic first_half;
      first_half = !p[3];
      return d ? (second ? !first_half : first_half)
               : (second ? first_half : !first_half);
   endfunction : mag_falling

   // control fields
   assign out_dis    = ctrl[bopc_pkg::CTRL_DIS];
   assign wake       = ctrl[bopc_pkg::CTRL_WAKE];
   assign seq_run    = ctrl[bopc_pkg::CTRL_RUNN];
   assign ms_sel     = ctrl[bopc_pkg::CTRL_MS +: 2];
   assign dir        = ctrl[bopc_pkg::CTRL_DIR];
   assign ots_supply = ctrl[bopc_pkg::CTRL_OTS];

   // every analog indication crosses two flops before use
   assign async_in = {fault_pins, sense1_pins, sense2_pins};

   bopc_sync #(
      .W     (10)
   ) u_sync (
      .clk   (hclk),
      .rst_n (hresetn),
      .d     (async_in),
      .q     (sync_out)
   );

   assign fault  = sync_out[9:6];
   assign sense1 = sync_out[5:3];
   assign sense2 = sync_out[2:0];

   // any supply or temperature fault stops both bridges, no latching
   assign fault_any = fault.over_temp || fault.charge_pump_rail_uv
                      || fault.gate_drive_regulator_fault
                      || fault.undervoltage_lockout;

   // bridges may conduct only with every gate condition clear
   assign run = !out_dis && wake && seq_run && !fault_any;

   // low power also stops the pump and the current regulator
   assign pump_enable      = wake;
   assign regulator_enable = wake;

   // ahb-lite: zero wait states, always okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign bus_take  = hsel && htrans[1] && hready;

   // address phase captured for the write that follows
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         wr_pend <= bus_take && hwrite;
         wr_addr <= haddr;
      end
   end

   // read mux; unmapped offsets read as zero
   always_comb begin
      rd_val = 32'h00000000;
      case (haddr)
         bopc_pkg::OFS_CTRL: begin
            rd_val[bopc_pkg::CTRL_W-1:0] = ctrl;
         end
         bopc_pkg::OFS_STATUS: begin
            rd_val[bopc_pkg::ST_RUN]        = run;
            rd_val[bopc_pkg::ST_LATCH1]     = latched1;
            rd_val[bopc_pkg::ST_LATCH2]     = latched2;
            rd_val[bopc_pkg::ST_FAULT +: 4] = fault;
            rd_val[bopc_pkg::ST_CHOP1 +: 5] = chop1;
            rd_val[bopc_pkg::ST_CHOP2 +: 5] = chop2;
         end
         bopc_pkg::OFS_POS: begin
            rd_val[bopc_pkg::POS_W-1:0] = step_index;
         end
         default: begin
            rd_val = 32'h00000000;
         end
      endcase
   end

   // read data sampled in the address phase, stands in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (bus_take && !hwrite) begin
         hrdata <= rd_val;
      end
   end

   // control register written in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= bopc_pkg::CTRL_RESET;
      end else if (wr_pend && wr_addr == bopc_pkg::OFS_CTRL) begin
         ctrl <= hwdata[bopc_pkg::CTRL_W-1:0];
      end
   end

   // step command: one-cycle pulse on a write of bit 0
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         step_req <= 1'b0;
      end else begin
         step_req <= wr_pend && wr_addr == bopc_pkg::OFS_STEP && hwdata[0];
      end
   end

   // wake edge clears short latches and homes the sequencer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= wake;
      end
   end
   assign wake_rise = wake && !wake_q;

   // increment per step from the microstep select
   always_comb begin
      case (ms_sel)
         2'h0: step_inc = 5'h08;
         2'h1: step_inc = 5'h04;
         2'h2: step_inc = 5'h02;
         default: step_inc = 5'h01;
      endcase
   end

   // translator position; independent of the disable bit
   always_comb begin
      next_pos = step_index;
      if (fault.undervoltage_lockout || !seq_run || wake_rise) begin
         next_pos = bopc_pkg::HOME_IDX;
      end else if (step_req && wake) begin
         next_pos = dir ? step_index + step_inc
                        : step_index - step_inc;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         step_index <= bopc_pkg::HOME_IDX;
      end else begin
         step_index <= next_pos;
      end
   end

   // winding polarity from the position, registered for the dac side
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase1_positive <= 1'b1;
         phase2_positive <= 1'b1;
      end else begin
         phase1_positive <= step_index < 5'h08 || step_index > 5'h18;
         phase2_positive <= step_index > 5'h00 && step_index < 5'h10;
      end
   end

   // decay: grounded select is always mixed; full step is slow
   assign mixed1 = !ots_supply
                   || (ms_sel != 2'h0 && mag_falling(step_index, dir, 1'b0));
   assign mixed2 = !ots_supply
                   || (ms_sel != 2'h0 && mag_falling(step_index, dir, 1'b1));

   // one fixed off-time chopper per full bridge
   bopc_chopper u_chop1 (
      .clk         (hclk),
      .rst_n       (hresetn),
      .run         (run),
      .positive    (phase1_positive),
      .mixed       (mixed1),
      .clear_latch (wake_rise),
      .sense       (sense1),
      .gate        (bridge1_gate),
      .latched     (latched1),
      .state       (chop1)
   );

   bopc_chopper u_chop2 (
      .clk         (hclk),
      .rst_n       (hresetn),
      .run         (run),
      .positive    (phase2_positive),
      .mixed       (mixed2),
      .clear_latch (wake_rise),
      .sense       (sense2),
      .gate        (bridge2_gate),
      .latched     (latched2),
      .state       (chop2)
   );

   sequence s_gates_off;
      bridge1_gate == '0 && bridge2_gate == '0;
   endsequence

   a_disable_gates_off: assert property (@(posedge hclk)
      disable iff (!hresetn) out_dis |-> ##2 s_gates_off)
      else $error("gates on while outputs disabled");

   a_fault_gates_off: assert property (@(posedge hclk)
      disable iff (!hresetn) fault_any |-> ##2 s_gates_off)
      else $error("gates on during a supply fault");

   a_sleep_gates_off: assert property (@(posedge hclk)
      disable iff (!hresetn) !wake |-> !pump_enable ##2 s_gates_off)
      else $error("low power left gates or pump on");

   a_reset_homes: assert property (@(posedge hclk)
      disable iff (!hresetn)
      !seq_run |=> step_index == bopc_pkg::HOME_IDX)
      else $error("sequencer reset did not hold home");

   a_lockout_homes: assert property (@(posedge hclk)
      disable iff (!hresetn)
      fault.undervoltage_lockout |=> step_index == bopc_pkg::HOME_IDX
      ##1 s_gates_off)
      else $error("power-on lockout did not home and stop");

   a_wake_homes: assert property (@(posedge hclk)
      disable iff (!hresetn)
      wake_rise |=> step_index == bopc_pkg::HOME_IDX)
      else $error("wake did not return home");

   a_step_disabled: assert property (@(posedge hclk)
      disable iff (!hresetn)
      step_req && out_dis && wake && seq_run
      && !fault.undervoltage_lockout && !wake_rise
      |=> step_index != $past(step_index))
      else $error("step lost while outputs disabled");

   a_fault_resumes: assert property (@(posedge hclk)
      disable iff (!hresetn)
      $fell(fault_any) && run |=> chop1 == bopc_pkg::CH_BLANK
      || latched1)
      else $error("bridge did not resume after fault cleared");
endmodule : bopc_top

// File: test/bopc_ctl_model.sv
`timescale 1ns/1ns
// controller side: ahb-lite master that steps only after the pump settles
module bopc_ctl_model (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite master
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic [7:0]       haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   time  wake_t;
   logic awake;
   // bus idle at time zero
   initial begin
      {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
      wake_t = 0;
      awake  = 1'b0;
   end
   // one single word transfer; nothing moves until hready is seen high
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize  <= 3'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
      if (w && a == bopc_pkg::OFS_CTRL && d[1] && !awake) wake_t = $time;
      if (w && a == bopc_pkg::OFS_CTRL) awake = d[1];
   endtask : xfer
   // pump needs time after low power, so hold the first step back
   task automatic step;
      logic [31:0] q;
      while ($time - wake_t < 64'd1000000) @(posedge hclk);
      xfer(1'b1, bopc_pkg::OFS_STEP, 32'h00000001, q);
      // the position moves one edge after the write lands
      @(posedge hclk);
   endtask : step
endmodule : bopc_ctl_model

// File: test/bopc_top_test.sv
`timescale 1ns/1ns
module bopc_top_test;
   logic                  hclk, hresetn, hsel, hwrite, hreadyout;
   logic [7:0]            haddr;
   logic [1:0]            htrans;
   logic [2:0]            hsize;
   logic [31:0]           hwdata, hrdata, seed, n, obs, e;
   logic                  obs_v, pump_enable, regulator_enable;
   logic                  hresp, phase1_positive, phase2_positive;
   logic [4:0]            step_index;
   bopc_pkg::bopc_fault_t fault_pins;
   bopc_pkg::bopc_sense_t sense1_pins, sense2_pins;
   bopc_pkg::bopc_gate_t  bridge1_gate, bridge2_gate;
   logic [31:0]           exp_q[$];
   int                    num_errors = 0;
   int                    n_tests = 0;

   bopc_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
      .fault_pins, .sense1_pins, .sense2_pins, .bridge1_gate,
      .bridge2_gate, .step_index, .phase1_positive, .phase2_positive,
      .pump_enable, .regulator_enable);
   bopc_ctl_model u_ctl (.hclk, .hresetn, .hready(hreadyout), .hrdata,
      .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);

   // clock, 20 ns period
   initial hclk = 1'b0;
   always #10 hclk = ~hclk;

   function automatic logic [31:0] xs;
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic cyc(input int k);
      repeat (k) @(posedge hclk);
   endtask : cyc
   // expected value queued, observed value shown to the watcher
   task automatic note(input logic [31:0] x, input logic [31:0] got);
      exp_q.push_back(x);
      obs   <= got;
      obs_v <= 1'b1;
      @(posedge hclk);
      obs_v <= 1'b0;
      @(posedge hclk);
   endtask : note
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      u_ctl.xfer(1'b1, a, d, q);
   endtask : wr
   task automatic chk(input logic [7:0] a, input logic [31:0] x,
                      input logic [31:0] m);
      logic [31:0] q;
      u_ctl.xfer(1'b0, a, 32'h00000000, q);
      note(x, q & m);
   endtask : chk
   task automatic gates(input logic [7:0] x);
      note({24'h000000, x}, {24'h000000, bridge1_gate, bridge2_gate});
   endtask : gates
   task automatic close_out;
      if (num_errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : close_out

   // watcher: oldest note against what was observed
   always @(posedge hclk) begin
      if (obs_v === 1'b1) begin
         n_tests++;
         e = exp_q.pop_front();
         if (obs !== e) begin
            num_errors++;
            $display("wrong value at %0t: got %h want %h", $time, obs, e);
         end
      end
   end

   // watchdog sized for one settle wait plus the chopper runs
   initial begin
      cyc(70000);
      num_errors++;
      close_out();
   end

   // main sequence; full words of ctrl: 3E run, 3F disabled, 3C asleep
   initial begin
      hresetn = 1'b0;
      seed = 32'h00013473;
      {fault_pins, sense1_pins, sense2_pins, obs, obs_v} = '0;
      cyc(2);
      hresetn <= 1'b1;
      chk(bopc_pkg::OFS_CTRL, 32'h44, 32'hFF);
      chk(bopc_pkg::OFS_POS, 32'h4, 32'h1F);
      chk(8'h10, 32'h0, 32'hFFFFFFFF);
      gates(8'h00);
      wr(bopc_pkg::OFS_CTRL, 32'h3E);
      // control lands on the closing edge, so look one edge later
      cyc(1);
      note(32'h1, {31'h0, pump_enable & regulator_enable});
      n = xs() % 2 + 1;
      repeat (n) u_ctl.step();
      chk(bopc_pkg::OFS_POS, 4 + n, 32'h1F);
      wr(bopc_pkg::OFS_POS, xs());
      chk(bopc_pkg::OFS_POS, 4 + n, 32'h1F);
      wr(bopc_pkg::OFS_CTRL, 32'h3F);
      cyc(3);
      gates(8'h00);
      u_ctl.step();
      chk(bopc_pkg::OFS_POS, 5 + n, 32'h1F);
      wr(bopc_pkg::OFS_CTRL, 32'h3E);
      cyc(60);
      gates(8'h99);
      // load short: trip held, off-time repeats with a fast then slow split
      sense1_pins <= 3'b100;
      cyc(6);
      gates(8'h69);
      cyc(480);
      gates(8'h59);
      cyc(1110);
      gates(8'h69);
      sense1_pins <= 3'b101;
      cyc(6);
      gates(8'h09);
      sense1_pins <= 3'b000;
      cyc(1600);
      // every fault blocks both bridges and resumes on its own
      for (int i = 0; i < 4; i++) begin
         fault_pins <= 4'(1 << i);
         cyc(5);
         gates(8'h00);
         fault_pins <= 4'h0;
         cyc(60);
         gates(8'h99);
      end
      // auto decay in full step: a trip goes straight to slow decay
      wr(bopc_pkg::OFS_CTRL, 32'h66);
      sense1_pins <= 3'b100;
      cyc(6);
      gates(8'h59);
      sense1_pins <= 3'b010;
      cyc(8);
      gates(8'h09);
      sense1_pins <= 3'b000;
      cyc(100);
      gates(8'h09);
      chk(bopc_pkg::OFS_STATUS, 32'h2, 32'h2);
      wr(bopc_pkg::OFS_CTRL, 32'h3A);
      cyc(3);
      chk(bopc_pkg::OFS_POS, 32'h4, 32'h1F);
      u_ctl.step();
      chk(bopc_pkg::OFS_POS, 32'h4, 32'h1F);
      gates(8'h00);
      wr(bopc_pkg::OFS_CTRL, 32'h3C);
      cyc(3);
      note(32'h0, {26'h0, pump_enable, regulator_enable, bridge2_gate});
      wr(bopc_pkg::OFS_CTRL, 32'h3E);
      // the latch clears on the edge after the wake write lands
      cyc(1);
      chk(bopc_pkg::OFS_STATUS, 32'h0, 32'h2);
      cyc(60);
      gates(8'h99);
      note(32'h13, {25'h0, step_index, phase1_positive, phase2_positive});
      note(32'h0, {31'h0, hresp});
      close_out();
   end
endmodule : bopc_top_test
